/* rtl/sense_regs_pkg.sv */
// constants for the sensing front-end register bank
package sense_regs_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] idx_ch1_abs_thr = 6'h0c;
    localparam logic [5:0] idx_ch1_rate_thr = 6'h0d;
    localparam logic [5:0] idx_ch2_abs_thr = 6'h0e;
    localparam logic [5:0] idx_ch2_rate_thr = 6'h0f;
    localparam logic [5:0] idx_channel1_cap_offset = 6'h10;
    localparam logic [5:0] idx_channel2_cap_offset = 6'h11;
    localparam logic [5:0] idx_standby_rate_divider = 6'h12;
    localparam logic [5:0] idx_channel2_standby_subdivider = 6'h13;
    localparam logic [5:0] idx_frontend_irq_enable = 6'h14;
    localparam logic [5:0] idx_wake_control = 6'h15;
    localparam logic [5:0] idx_event_flags = 6'h16;

    // ------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------
    localparam int offset_width = 6;
    localparam int divider_width = 5;
    localparam int result_width = 12;
    localparam int thr_width = 8;
    localparam int thr_low_bits = 4;
    localparam int event_count = 4;
    // enable and flag bit positions (same layout in both registers)
    localparam int pos_ch1_ready = 0;
    localparam int pos_ch2_ready = 1;
    localparam int pos_ch1_wake = 2;
    localparam int pos_ch2_wake = 3;
    // wake control bit positions
    localparam int pos_ch1_abs_en = 0;
    localparam int pos_ch1_rate_en = 1;
    localparam int pos_ch2_abs_en = 2;
    localparam int pos_ch2_rate_en = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [offset_width-1:0] rst_cap_offset = 6'h00;
    localparam logic [divider_width-1:0] rst_divider = 5'h01;
    localparam logic [event_count-1:0] rst_irq_enable = 4'h0;
    localparam logic [event_count-1:0] rst_wake_control = 4'h0;
    localparam logic [event_count-1:0] rst_event_flags = 4'h0;
    localparam logic [thr_width-1:0] rst_threshold = 8'h00;

endpackage

/* rtl/wake_chan_if.sv */
// carrier between the register bank and one channel's wake detector
`timescale 1ns/100ps
interface wake_chan_if;
    import sense_regs_pkg::*;
    logic [result_width-1:0] result;
    logic result_valid;
    logic [thr_width-1:0] abs_thr;
    logic [thr_width-1:0] rate_thr;
    logic abs_en;
    logic rate_en;
    logic standby;
    logic wake_event;

    modport bank (output result, result_valid, abs_thr, rate_thr, abs_en, rate_en, standby,
                  input wake_event);
    modport detect (input result, result_valid, abs_thr, rate_thr, abs_en, rate_en, standby,
                    output wake_event);
endinterface

/* rtl/standby_rate_divider_unit.sv */
// conversion tick divider used while the front end is in standby
`timescale 1ns/100ps
module standby_rate_divider_unit #(
    parameter int width = 5
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // ticks
    input wire logic dividing,
    input wire logic tick_in,
    input wire logic [width-1:0] divisor,
    output logic tick_out
);
    logic [width-1:0] count_reg;
    logic last_tick;

    // a divisor of zero behaves as one, so the channel never stalls
    assign last_tick = (count_reg + 1'b1 >= divisor);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (!dividing) begin
            count_reg <= '0;
        end else if (tick_in) begin
            count_reg <= last_tick ? '0 : width'(count_reg + 1'b1);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= tick_in && (!dividing || last_tick);
        end
    end
endmodule

/* rtl/wake_threshold_detect.sv */
// standby wake-up detection on absolute level and rate of change
`timescale 1ns/100ps
module wake_threshold_detect
    import sense_regs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // channel carrier
    wake_chan_if.detect chan
);
    logic [result_width-1:0] prev_reg;
    logic have_prev_reg;
    logic [result_width-1:0] delta;
    logic abs_hit;
    logic rate_hit;

    // thresholds hold only the upper eight bits of a 12-bit value
    assign delta = (chan.result >= prev_reg) ? result_width'(chan.result - prev_reg)
                                             : result_width'(prev_reg - chan.result);
    assign abs_hit = chan.abs_en && (chan.result >= {chan.abs_thr, 4'h0});
    assign rate_hit = chan.rate_en && have_prev_reg && (delta >= {chan.rate_thr, 4'h0});

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prev_reg <= '0;
            have_prev_reg <= 1'b0;
        end else if (chan.result_valid) begin
            prev_reg <= chan.result;
            have_prev_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            chan.wake_event <= 1'b0;
        end else begin
            chan.wake_event <= chan.standby && chan.result_valid && (abs_hit || rate_hit);
        end
    end
endmodule

/* rtl/sense_offset_rate_irq_regs.sv */
// offset, standby rate and front-end interrupt register bank
`timescale 1ns/100ps

// Contract
// - each channel's offset register low six bits set 0 to 63 pF compensation
// - offset bits 7:6 and divider bits 7:5 read back as zero
// - both offset registers and the interrupt enable reset to zero
// - shared divider and channel 2 subdivider reset to one
// - in standby channel 1's conversion rate is divided by the shared divider
// - in standby channel 2 is divided by shared divider times its subdivider
// - enable bit 0 gates the channel 1 data-ready interrupt
// - enable bit 1 gates the channel 2 data-ready interrupt
// - enable bit 2 gates the channel 1 wake-up interrupt
// - enable bit 3 gates the channel 2 wake-up interrupt
// - in standby a conversion past an enabled threshold gives a wake-up event
module sense_offset_rate_irq_regs
    import sense_regs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // converter side
    input wire logic standby,
    input wire logic conv_tick,
    input wire logic ch1_done,
    input wire logic ch2_done,
    input wire logic [result_width-1:0] ch1_result,
    input wire logic [result_width-1:0] ch2_result,
    output logic ch1_conv_start,
    output logic ch2_conv_start,
    output logic [offset_width-1:0] ch1_cap_offset,
    output logic [offset_width-1:0] ch2_cap_offset,
    // processor interrupt
    output logic frontend_irq
);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [offset_width-1:0] channel1_cap_offset_reg;
    logic [offset_width-1:0] channel2_cap_offset_reg;
    logic [divider_width-1:0] standby_rate_divider_reg;
    logic [divider_width-1:0] channel2_standby_subdivider_reg;
    logic [event_count-1:0] frontend_irq_enable_reg;
    logic [event_count-1:0] wake_control_reg;
    logic [event_count-1:0] event_flags_reg;
    logic [event_count-1:0] event_flags_next;
    logic [thr_width-1:0] ch1_abs_thr_reg;
    logic [thr_width-1:0] ch1_rate_thr_reg;
    logic [thr_width-1:0] ch2_abs_thr_reg;
    logic [thr_width-1:0] ch2_rate_thr_reg;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic [5:0] index;
    logic word_aligned;
    logic wr_take;
    logic rd_take;
    logic lane0_wr;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic [event_count-1:0] flag_set;
    logic [event_count-1:0] flag_clear;
    logic ch2_stage_tick;

    assign index = address[7:2];
    assign word_aligned = (address[1:0] == 2'b00);
    // the access completes at the edge where waitrequest is seen low
    assign wr_take = write && !waitrequest;
    assign rd_take = read && !waitrequest;
    assign lane0_wr = wr_take && byteenable[0] && word_aligned;
    assign wbyte = writedata[7:0];

    // one wait state: waitrequest drops for exactly one cycle per request
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !(waitrequest && (read || write));
        end
    end

    // ------------------------------------------------------------
    // offset registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            channel1_cap_offset_reg <= rst_cap_offset;
            channel2_cap_offset_reg <= rst_cap_offset;
        end else if (lane0_wr) begin
            if (index == idx_channel1_cap_offset) begin
                channel1_cap_offset_reg <= wbyte[offset_width-1:0];
            end
            if (index == idx_channel2_cap_offset) begin
                channel2_cap_offset_reg <= wbyte[offset_width-1:0];
            end
        end
    end

    // one code step is one picofarad of compensation on the front end
    assign ch1_cap_offset = channel1_cap_offset_reg;
    assign ch2_cap_offset = channel2_cap_offset_reg;

    // ------------------------------------------------------------
    // standby divider registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            standby_rate_divider_reg <= rst_divider;
            channel2_standby_subdivider_reg <= rst_divider;
        end else if (lane0_wr) begin
            if (index == idx_standby_rate_divider) begin
                standby_rate_divider_reg <= wbyte[divider_width-1:0];
            end
            if (index == idx_channel2_standby_subdivider) begin
                channel2_standby_subdivider_reg <= wbyte[divider_width-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt enable and wake control
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            frontend_irq_enable_reg <= rst_irq_enable;
            wake_control_reg <= rst_wake_control;
        end else if (lane0_wr) begin
            if (index == idx_frontend_irq_enable) begin
                frontend_irq_enable_reg <= wbyte[event_count-1:0];
            end
            if (index == idx_wake_control) begin
                wake_control_reg <= wbyte[event_count-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // wake thresholds
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ch1_abs_thr_reg <= rst_threshold;
            ch1_rate_thr_reg <= rst_threshold;
            ch2_abs_thr_reg <= rst_threshold;
            ch2_rate_thr_reg <= rst_threshold;
        end else if (lane0_wr) begin
            if (index == idx_ch1_abs_thr) begin
                ch1_abs_thr_reg <= wbyte;
            end
            if (index == idx_ch1_rate_thr) begin
                ch1_rate_thr_reg <= wbyte;
            end
            if (index == idx_ch2_abs_thr) begin
                ch2_abs_thr_reg <= wbyte;
            end
            if (index == idx_ch2_rate_thr) begin
                ch2_rate_thr_reg <= wbyte;
            end
        end
    end

    // ------------------------------------------------------------
    // conversion pacing
    // ------------------------------------------------------------
    // channel 2 runs through the shared stage and then its own stage, so its
    // ratio is the product of both dividers at the cost of one extra cycle
    standby_rate_divider_unit #(
        .width(divider_width)
    ) ch1_divider (
        .clock(clock),
        .rst(rst),
        .dividing(standby),
        .tick_in(conv_tick),
        .divisor(standby_rate_divider_reg),
        .tick_out(ch1_conv_start)
    );

    standby_rate_divider_unit #(
        .width(divider_width)
    ) ch2_shared_divider (
        .clock(clock),
        .rst(rst),
        .dividing(standby),
        .tick_in(conv_tick),
        .divisor(standby_rate_divider_reg),
        .tick_out(ch2_stage_tick)
    );

    standby_rate_divider_unit #(
        .width(divider_width)
    ) ch2_sub_divider (
        .clock(clock),
        .rst(rst),
        .dividing(standby),
        .tick_in(ch2_stage_tick),
        .divisor(channel2_standby_subdivider_reg),
        .tick_out(ch2_conv_start)
    );

    // ------------------------------------------------------------
    // wake detection
    // ------------------------------------------------------------
    wake_chan_if ch1_wake ();
    wake_chan_if ch2_wake ();

    assign ch1_wake.result = ch1_result;
    assign ch1_wake.result_valid = ch1_done;
    assign ch1_wake.abs_thr = ch1_abs_thr_reg;
    assign ch1_wake.rate_thr = ch1_rate_thr_reg;
    assign ch1_wake.abs_en = wake_control_reg[pos_ch1_abs_en];
    assign ch1_wake.rate_en = wake_control_reg[pos_ch1_rate_en];
    assign ch1_wake.standby = standby;

    assign ch2_wake.result = ch2_result;
    assign ch2_wake.result_valid = ch2_done;
    assign ch2_wake.abs_thr = ch2_abs_thr_reg;
    assign ch2_wake.rate_thr = ch2_rate_thr_reg;
    assign ch2_wake.abs_en = wake_control_reg[pos_ch2_abs_en];
    assign ch2_wake.rate_en = wake_control_reg[pos_ch2_rate_en];
    assign ch2_wake.standby = standby;

    wake_threshold_detect ch1_detect (
        .clock(clock),
        .rst(rst),
        .chan(ch1_wake)
    );

    wake_threshold_detect ch2_detect (
        .clock(clock),
        .rst(rst),
        .chan(ch2_wake)
    );

    // ------------------------------------------------------------
    // event flags
    // ------------------------------------------------------------
    always_comb begin
        flag_set = '0;
        flag_set[pos_ch1_ready] = ch1_done;
        flag_set[pos_ch2_ready] = ch2_done;
        flag_set[pos_ch1_wake] = ch1_wake.wake_event;
        flag_set[pos_ch2_wake] = ch2_wake.wake_event;
        flag_clear = (lane0_wr && index == idx_event_flags) ? wbyte[event_count-1:0] : '0;
        // a new event in the clearing cycle must survive, so set beats clear
        event_flags_next = (event_flags_reg & ~flag_clear) | flag_set;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            event_flags_reg <= rst_event_flags;
        end else begin
            event_flags_reg <= event_flags_next;
        end
    end

    // ------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            frontend_irq <= 1'b0;
        end else begin
            frontend_irq <=
                (event_flags_next[pos_ch1_ready]
                    && frontend_irq_enable_reg[pos_ch1_ready])
                || (event_flags_next[pos_ch2_ready]
                    && frontend_irq_enable_reg[pos_ch2_ready])
                || (event_flags_next[pos_ch1_wake]
                    && frontend_irq_enable_reg[pos_ch1_wake])
                || (event_flags_next[pos_ch2_wake]
                    && frontend_irq_enable_reg[pos_ch2_wake]);
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        rbyte = 8'h00;
        if (word_aligned) begin
            unique case (index)
                idx_ch1_abs_thr: rbyte = ch1_abs_thr_reg;
                idx_ch1_rate_thr: rbyte = ch1_rate_thr_reg;
                idx_ch2_abs_thr: rbyte = ch2_abs_thr_reg;
                idx_ch2_rate_thr: rbyte = ch2_rate_thr_reg;
                idx_channel1_cap_offset: rbyte = {2'b00, channel1_cap_offset_reg};
                idx_channel2_cap_offset: rbyte = {2'b00, channel2_cap_offset_reg};
                idx_standby_rate_divider: rbyte = {3'b000, standby_rate_divider_reg};
                idx_channel2_standby_subdivider: begin
                    rbyte = {3'b000, channel2_standby_subdivider_reg};
                end
                idx_frontend_irq_enable: rbyte = {4'h0, frontend_irq_enable_reg};
                idx_wake_control: rbyte = {4'h0, wake_control_reg};
                idx_event_flags: rbyte = {4'h0, event_flags_reg};
                default: rbyte = 8'h00;
            endcase
        end
    end

    // read data is loaded in the wait cycle, so it stands at the completing edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if (read && waitrequest) begin
            readdata <= {24'h00_0000, rbyte};
        end
    end

endmodule

/* dv/sense_offset_rate_irq_regs_asserts.sv */
// concurrent checks on the ports of the offset, rate and interrupt register bank
`timescale 1ns/100ps
module sense_offset_rate_irq_regs_asserts
    import sense_regs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // converter side
    input wire logic standby,
    input wire logic conv_tick,
    input wire logic ch1_conv_start,
    input wire logic ch2_conv_start,
    input wire logic [offset_width-1:0] ch1_cap_offset,
    input wire logic frontend_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    logic [5:0] idx;
    logic rd_ok;
    logic wr_off1;
    logic [offset_width-1:0] off1_reg;
    assign idx = address[7:2];
    assign rd_ok = read && !waitrequest && address[1:0] == 2'b00;
    assign wr_off1 = write && !waitrequest && address == {idx_channel1_cap_offset, 2'b00}
        && byteenable[0];
    // last code written to the channel 1 offset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            off1_reg <= 6'h00;
        end else if (wr_off1) begin
            off1_reg <= writedata[5:0];
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_one_wait; !waitrequest |=> waitrequest; endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait low too long");
    property p_answer; (read || write) && waitrequest |=> !waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("no answer after one wait");
    property p_upper_zero; !waitrequest && read |-> readdata[31:8] == 24'h000000; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    property p_offset_rsv;
        rd_ok && (idx == idx_channel1_cap_offset || idx == idx_channel2_cap_offset)
            |-> readdata[7:6] == 2'b00;
    endproperty
    a_offset_rsv: assert property (p_offset_rsv) else $error("offset spare bits set");
    property p_div_rsv;
        rd_ok && (idx == idx_standby_rate_divider || idx == idx_channel2_standby_subdivider)
            |-> readdata[7:5] == 3'b000;
    endproperty
    a_div_rsv: assert property (p_div_rsv) else $error("divider spare bits set");
    property p_offset_port; wr_off1 |-> ##[1:2] ch1_cap_offset == off1_reg; endproperty
    a_offset_port: assert property (p_offset_port) else $error("offset port mismatch");
    property p_reset_clear;
        $fell(rst) |-> ch1_cap_offset == 6'h00 && !frontend_irq && waitrequest;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared");
    property p_ch1_pass; !standby && conv_tick |=> ch1_conv_start; endproperty
    a_ch1_pass: assert property (p_ch1_pass) else $error("ch1 start missing");
    property p_ch2_pass; !standby && conv_tick ##1 !standby |=> ch2_conv_start; endproperty
    a_ch2_pass: assert property (p_ch2_pass) else $error("ch2 start missing");
    property p_ch1_cause; ch1_conv_start |-> $past(conv_tick); endproperty
    a_ch1_cause: assert property (p_ch1_cause) else $error("ch1 start, no tick");
    property p_ch2_cause; ch2_conv_start |-> $past(conv_tick, 2); endproperty
    a_ch2_cause: assert property (p_ch2_cause) else $error("ch2 start, no tick");

    c_read: cover property (rd_ok);
    c_offset_write: cover property (wr_off1);
    c_standby_tick: cover property (standby && conv_tick);
    c_irq: cover property ($rose(frontend_irq));
endmodule

bind sense_offset_rate_irq_regs sense_offset_rate_irq_regs_asserts
    u_sense_offset_rate_irq_regs_asserts (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .standby(standby), .conv_tick(conv_tick),
    .ch1_conv_start(ch1_conv_start), .ch2_conv_start(ch2_conv_start),
    .ch1_cap_offset(ch1_cap_offset), .frontend_irq(frontend_irq));

/* dv/sense_offset_rate_irq_regs_test.sv */
// self-checking testbench for the offset, rate and interrupt register bank
`timescale 1ns/100ps
module sense_offset_rate_irq_regs_test
    import sense_regs_pkg::*;
;
    logic clock = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, standby = 1'b0, conv_tick = 1'b0;
    logic ch1_done = 1'b0, ch2_done = 1'b0, waitrequest, frontend_irq;
    logic ch1_conv_start, ch2_conv_start;
    logic [7:0] address = 8'h00;
    logic [31:0] writedata = 32'h00000000;
    logic [3:0] byteenable = 4'h0;
    logic [11:0] ch1_result = 12'h000, ch2_result = 12'h000;
    logic [31:0] readdata, rd_val;
    logic [5:0] ch1_cap_offset, ch2_cap_offset;
    int errors = 0, tests_run = 0, starts1 = 0, starts2 = 0;

    sense_offset_rate_irq_regs u_sense_offset_rate_irq_regs (.*);

    always #5 clock = ~clock;
    always @(negedge clock) begin
        if (ch1_conv_start === 1'b1) starts1++;
        if (ch2_conv_start === 1'b1) starts2++;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // bounded wait, so a hang cannot stall the run
    task automatic bus_wait;
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) check("waitrequest", 32'h1, 32'h0);
    endtask
    task automatic reg_write(input logic [5:0] idx, input logic [7:0] data);
        @(posedge clock);
        address <= {idx, 2'b00};
        writedata <= {24'h000000, data};
        byteenable <= 4'h1;
        write <= 1'b1;
        bus_wait;
        write <= 1'b0;
    endtask
    task automatic reg_read(input logic [5:0] idx, output logic [31:0] data);
        @(posedge clock);
        address <= {idx, 2'b00};
        read <= 1'b1;
        bus_wait;
        data = readdata;
        read <= 1'b0;
    endtask
    task automatic pulse_ticks(input int n);
        repeat (n) begin
            @(posedge clock);
            conv_tick <= 1'b1;
        end
        @(posedge clock);
        conv_tick <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset_values;
        logic [7:0] exp [5] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
        for (int i = 0; i < 5; i++) begin
            reg_read(idx_channel1_cap_offset + 6'(i), rd_val);
            check("reset value", rd_val, {24'h000000, exp[i]});
        end
        check("ch2 offset port", {26'h0, ch2_cap_offset}, 32'h0);
        $display("test reset values done");
    endtask
    task automatic test_fields;
        logic [7:0] wr [4] = '{8'hff, 8'hea, 8'hff, 8'hff};
        logic [7:0] exp [4] = '{8'h3f, 8'h2a, 8'h1f, 8'h1f};
        for (int i = 0; i < 4; i++) reg_write(idx_channel1_cap_offset + 6'(i), wr[i]);
        for (int i = 0; i < 4; i++) begin
            reg_read(idx_channel1_cap_offset + 6'(i), rd_val);
            check("spare bits", rd_val, {24'h000000, exp[i]});
        end
        check("ch1 offset port", {26'h0, ch1_cap_offset}, 32'h3f);
        check("ch2 offset port", {26'h0, ch2_cap_offset}, 32'h2a);
        reg_read(6'h3f, rd_val);
        check("unmapped read", rd_val, 32'h0);
        $display("test fields done");
    endtask
    task automatic test_rates;
        reg_write(idx_standby_rate_divider, 8'h03);
        reg_write(idx_channel2_standby_subdivider, 8'h02);
        @(posedge clock);
        standby <= 1'b1;
        starts1 = 0;
        starts2 = 0;
        // twelve ticks are a whole number of both periods, whatever the phase
        pulse_ticks(12);
        check("ch1 standby starts", starts1, 32'd4);
        check("ch2 standby starts", starts2, 32'd2);
        @(posedge clock);
        standby <= 1'b0;
        starts1 = 0;
        starts2 = 0;
        pulse_ticks(5);
        check("ch1 active starts", starts1, 32'd5);
        check("ch2 active starts", starts2, 32'd5);
        $display("test rates done");
    endtask
    task automatic test_irq_gating;
        reg_write(idx_wake_control, 8'h0f);
        for (int i = 0; i < 4; i++) begin
            reg_write(idx_event_flags, 8'h0f);
            reg_write(idx_frontend_irq_enable, 8'h00);
            @(posedge clock);
            standby <= (i >= 2);
            ch1_done <= (i % 2 == 0);
            ch2_done <= (i % 2 == 1);
            ch1_result <= 12'h800;
            ch2_result <= 12'h800;
            @(posedge clock);
            ch1_done <= 1'b0;
            ch2_done <= 1'b0;
            repeat (4) @(posedge clock);
            check("irq masked", frontend_irq, 32'h0);
            reg_read(idx_event_flags, rd_val);
            check("ready flag", rd_val[i % 2], 32'h1);
            check("wake flag", rd_val[(i % 2) + 2], 32'(i >= 2));
            reg_write(idx_frontend_irq_enable, 8'(1 << i));
            repeat (2) @(posedge clock);
            check("irq enabled", frontend_irq, 32'h1);
            reg_write(idx_event_flags, 8'h0f);
            repeat (2) @(posedge clock);
            check("irq cleared", frontend_irq, 32'h0);
            standby <= 1'b0;
        end
        $display("test irq gating done");
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        test_reset_values;
        test_fields;
        test_rates;
        test_irq_gating;
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        test_reset_values;
        print_verdict;
    end
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        print_verdict;
    end
endmodule
